// ### core/usda_pkg.sv
// Constants for the aliased UART receive/transmit data port
package usda_pkg;

    // Alias window: sixteen words, alias 2 at its printed address
    localparam logic [31:0] ALIAS_BASE = 32'h5000_1030;
    localparam logic [31:0] ALIAS_2_ADDR = 32'h5000_1038;
    localparam logic [31:0] ALIAS_SPAN = 32'h0000_0040;

    // Control and line status words
    localparam logic [31:0] CTRL_ADDR = 32'h5000_1080;
    localparam logic [31:0] LINE_STATUS_ADDR = 32'h5000_1084;

    // Control field positions
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_IR_MODE_BIT = 1;

    // Line status field positions
    localparam int LSR_DATA_READY_BIT = 0;
    localparam int LSR_OVERRUN_BIT = 1;
    localparam int LSR_HOLDING_EMPTY_BIT = 5;

    // Reset values
    localparam logic CTRL_FIFO_EN_RESET = 1'b0;
    localparam logic CTRL_IR_MODE_RESET = 1'b0;
    localparam logic [7:0] DATA_RESET = 8'h00;

    // FIFO geometry
    localparam int FIFO_PTR_W = 4;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : usda_pkg

// ### core/usda_top.sv
// Aliased UART data port with receive and transmit FIFOs over AXI4-Lite
`timescale 1ns/1ps

module usda_top (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,

    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,

    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,

    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,

    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,

    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,

    // Received characters from the deserialisers
    input wire logic [7:0] rx_uart_byte_i,
    input wire logic rx_uart_valid_i,
    input wire logic [7:0] rx_ir_byte_i,
    input wire logic rx_ir_valid_i,

    // Characters toward the serialisers
    output logic [7:0] tx_byte_o,
    output logic tx_uart_valid_o,
    output logic tx_ir_valid_o,
    input wire logic tx_take_i,

    // Flags toward the rest of the UART
    output logic rx_data_ready_flag_o,
    output logic tx_holding_empty_flag_o,
    output logic overrun_o,
    output logic fifo_enable_o
);

    // Any of the sixteen word-aligned aliases
    function automatic logic is_alias(input logic [31:0] a);
        is_alias = (a >= usda_pkg::ALIAS_BASE) &&
                   (a < (usda_pkg::ALIAS_BASE + usda_pkg::ALIAS_SPAN)) &&
                   (a[1:0] == 2'h0);
    endfunction : is_alias

    // Bus state and next values
    logic awready, wready, aw_held, w_held, w_lane0, bvalid, arready, rvalid;
    logic [31:0] aw_addr, rdata, next_aw_addr, next_rdata;
    logic [7:0] w_byte, next_w_byte;
    logic [1:0] bresp, rresp, next_bresp, next_rresp;
    logic next_awready, next_wready, next_aw_held, next_w_held;
    logic next_w_lane0, next_bvalid, next_arready, next_rvalid;

    // Control and status state
    logic fifo_en, ir_mode, overrun;
    logic next_fifo_en, next_ir_mode, next_overrun;

    // Receive store
    logic [7:0] rx_mem [16];
    logic [3:0] rx_rd, rx_wr, next_rx_rd, next_rx_wr, rx_waddr;
    logic [4:0] rx_cnt, next_rx_cnt;
    logic rx_wen;
    logic [7:0] rx_wdata;

    // Transmit store
    logic [7:0] tx_mem [16];
    logic [3:0] tx_rd, tx_wr, next_tx_rd, next_tx_wr, tx_waddr;
    logic [4:0] tx_cnt, next_tx_cnt;
    logic tx_wen;
    logic [7:0] tx_wdata;

    // Registered line-side outputs
    logic [7:0] tx_byte, next_tx_byte;
    logic tx_uart_valid, tx_ir_valid, dr_flag, tx_holding_empty_flag_flag;
    logic next_tx_uart_valid, next_tx_ir_valid, next_dr_flag, next_tx_holding_empty_flag_flag;

    // Decoded events shared by both groups
    logic wr_fire, wr_alias, wr_ctrl, rd_take, rd_alias, rd_status, flush;

    assign wr_fire = aw_held && w_held && !bvalid;
    assign wr_alias = wr_fire && is_alias(aw_addr) && w_lane0;
    assign wr_ctrl = wr_fire && (aw_addr == usda_pkg::CTRL_ADDR) && w_lane0;
    assign rd_take = s_axi_arvalid_i && arready;
    assign rd_alias = rd_take && is_alias(s_axi_araddr_i);
    assign rd_status = rd_take &&
                       (s_axi_araddr_i == usda_pkg::LINE_STATUS_ADDR);
    // Switching FIFO mode empties both stores, so no half-valid queue
    assign flush = wr_ctrl &&
        (w_byte[usda_pkg::CTRL_FIFO_EN_BIT] != fifo_en);

    // Bus handshakes, control register and read data
    always_comb begin
        logic [31:0] stat;
        stat = 32'h0000_0000;
        next_awready = awready;
        next_wready = wready;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_arready = arready;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_fifo_en = fifo_en;
        next_ir_mode = ir_mode;
        stat[usda_pkg::LSR_DATA_READY_BIT] = dr_flag;
        stat[usda_pkg::LSR_OVERRUN_BIT] = overrun;
        stat[usda_pkg::LSR_HOLDING_EMPTY_BIT] = tx_holding_empty_flag_flag;
        // Address and data are caught in either order
        if (s_axi_awvalid_i && awready) begin
            next_aw_held = 1'b1;
            next_awready = 1'b0;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && wready) begin
            next_w_held = 1'b1;
            next_wready = 1'b0;
            next_w_byte = s_axi_wdata_i[7:0];
            next_w_lane0 = s_axi_wstrb_i[0];
        end
        if (wr_fire) begin
            next_bvalid = 1'b1;
            if (is_alias(aw_addr) || (aw_addr == usda_pkg::CTRL_ADDR) ||
                (aw_addr == usda_pkg::LINE_STATUS_ADDR)) begin
                next_bresp = usda_pkg::RESP_OKAY;
            end else begin
                next_bresp = usda_pkg::RESP_SLVERR;
            end
        end
        if (wr_ctrl) begin
            next_fifo_en = w_byte[usda_pkg::CTRL_FIFO_EN_BIT];
            next_ir_mode = w_byte[usda_pkg::CTRL_IR_MODE_BIT];
        end
        // Readies return only once the response is accepted
        if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_awready = 1'b1;
            next_wready = 1'b1;
        end
        // Read answered one cycle after the address is taken
        if (rd_take) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = usda_pkg::RESP_OKAY;
            if (is_alias(s_axi_araddr_i)) begin
                // Empty store reads zero, never an unwritten slot
                if (rx_cnt != 5'h00) begin
                    next_rdata = {24'h000000, rx_mem[rx_rd]};
                end else begin
                    next_rdata = 32'h0000_0000;
                end
            end else if (s_axi_araddr_i == usda_pkg::CTRL_ADDR) begin
                next_rdata = {30'h0000_0000, ir_mode, fifo_en};
            end else if (s_axi_araddr_i == usda_pkg::LINE_STATUS_ADDR) begin
                next_rdata = stat;
            end else begin
                next_rdata = 32'h0000_0000;
                next_rresp = usda_pkg::RESP_SLVERR;
            end
        end
        if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    // Bus and control registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_byte <= usda_pkg::DATA_RESET;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= usda_pkg::RESP_OKAY;
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= usda_pkg::RESP_OKAY;
            fifo_en <= usda_pkg::CTRL_FIFO_EN_RESET;
            ir_mode <= usda_pkg::CTRL_IR_MODE_RESET;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            fifo_en <= next_fifo_en;
            ir_mode <= next_ir_mode;
        end
    end

    // Receive and transmit stores, flags and line outputs
    always_comb begin
        logic rx_arrive;
        logic [7:0] rx_in;
        logic rx_pop;
        logic [4:0] rx_left;
        logic tx_pop;
        logic [4:0] tx_left;
        logic ovr_evt;
        rx_arrive = ir_mode ? rx_ir_valid_i : rx_uart_valid_i;
        rx_in = ir_mode ? rx_ir_byte_i : rx_uart_byte_i;
        rx_pop = rd_alias && (rx_cnt != 5'h00);
        rx_left = rx_cnt - {4'h0, rx_pop};
        tx_pop = tx_take_i && (tx_cnt != 5'h00);
        tx_left = tx_cnt - {4'h0, tx_pop};
        ovr_evt = 1'b0;
        rx_wen = 1'b0;
        rx_waddr = rx_wr;
        rx_wdata = rx_in;
        tx_wen = 1'b0;
        tx_waddr = tx_wr;
        tx_wdata = w_byte;
        next_rx_rd = rx_rd + {3'h0, rx_pop};
        next_rx_wr = rx_wr;
        next_rx_cnt = rx_left;
        next_tx_rd = tx_rd + {3'h0, tx_pop};
        next_tx_wr = tx_wr;
        next_tx_cnt = tx_left;
        // Receive side
        if (rx_arrive) begin
            if (fifo_en && (rx_left == usda_pkg::FIFO_DEPTH)) begin
                ovr_evt = 1'b1;
            end else if (!fifo_en && (rx_left != 5'h00)) begin
                rx_wen = 1'b1;
                rx_waddr = rx_rd;
                ovr_evt = 1'b1;
            end else begin
                rx_wen = 1'b1;
                next_rx_wr = rx_wr + 4'h1;
                next_rx_cnt = rx_left + 5'h01;
            end
        end
        // Transmit side; software is trusted to wait for holding-empty
        if (wr_alias) begin
            if (fifo_en && (tx_left == usda_pkg::FIFO_DEPTH)) begin
                tx_wen = 1'b0;
            end else if (!fifo_en && (tx_left != 5'h00)) begin
                tx_wen = 1'b1;
                tx_waddr = tx_rd;
            end else begin
                tx_wen = 1'b1;
                next_tx_wr = tx_wr + 4'h1;
                next_tx_cnt = tx_left + 5'h01;
            end
        end
        if (flush) begin
            rx_wen = 1'b0;
            tx_wen = 1'b0;
            next_rx_rd = 4'h0;
            next_rx_wr = 4'h0;
            next_rx_cnt = 5'h00;
            next_tx_rd = 4'h0;
            next_tx_wr = 4'h0;
            next_tx_cnt = 5'h00;
        end
        // Overrun is sticky; a new event beats the clear-on-read
        next_overrun = (overrun && !rd_status) || ovr_evt;
        next_dr_flag = next_rx_cnt != 5'h00;
        next_tx_holding_empty_flag_flag = next_tx_cnt == 5'h00;
        // Head byte looks through a same-cycle write into its slot
        if (next_tx_cnt == 5'h00) begin
            next_tx_byte = usda_pkg::DATA_RESET;
        end else if (tx_wen && (tx_waddr == next_tx_rd)) begin
            next_tx_byte = tx_wdata;
        end else begin
            next_tx_byte = tx_mem[next_tx_rd];
        end
        next_tx_uart_valid = (next_tx_cnt != 5'h00) && !next_ir_mode;
        next_tx_ir_valid = (next_tx_cnt != 5'h00) && next_ir_mode;
    end

    // Store memories: written only, never reset, to stay RAM-like
    always_ff @(posedge mclk_i) begin
        if (rx_wen) begin
            rx_mem[rx_waddr] <= rx_wdata;
        end
        if (tx_wen) begin
            tx_mem[tx_waddr] <= tx_wdata;
        end
    end

    // Store pointers, flags and line outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rx_rd <= 4'h0;
            rx_wr <= 4'h0;
            rx_cnt <= 5'h00;
            tx_rd <= 4'h0;
            tx_wr <= 4'h0;
            tx_cnt <= 5'h00;
            overrun <= 1'b0;
            dr_flag <= 1'b0;
            tx_holding_empty_flag_flag <= 1'b1;
            tx_byte <= usda_pkg::DATA_RESET;
            tx_uart_valid <= 1'b0;
            tx_ir_valid <= 1'b0;
        end else begin
            rx_rd <= next_rx_rd;
            rx_wr <= next_rx_wr;
            rx_cnt <= next_rx_cnt;
            tx_rd <= next_tx_rd;
            tx_wr <= next_tx_wr;
            tx_cnt <= next_tx_cnt;
            overrun <= next_overrun;
            dr_flag <= next_dr_flag;
            tx_holding_empty_flag_flag <= next_tx_holding_empty_flag_flag;
            tx_byte <= next_tx_byte;
            tx_uart_valid <= next_tx_uart_valid;
            tx_ir_valid <= next_tx_ir_valid;
        end
    end

    // Port drive, all from flip-flops
    assign s_axi_awready_o = awready;
    assign s_axi_wready_o = wready;
    assign s_axi_bresp_o = bresp;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_arready_o = arready;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign s_axi_rvalid_o = rvalid;
    assign tx_byte_o = tx_byte;
    assign tx_uart_valid_o = tx_uart_valid;
    assign tx_ir_valid_o = tx_ir_valid;
    assign rx_data_ready_flag_o = dr_flag;
    assign tx_holding_empty_flag_o = tx_holding_empty_flag_flag;
    assign overrun_o = overrun;
    assign fifo_enable_o = fifo_en;

endmodule : usda_top

// ### dv/usda_peer.sv
// Serial peer model: feeds received characters, takes sent ones
`timescale 1ns/1ps
module usda_peer (
    // Clock and stall control
    input wire logic mclk_i,
    input wire logic stall_i,
    // Characters from the block
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_uart_valid_i,
    input wire logic tx_ir_valid_i,
    output logic tx_take_o = 1'b0,
    // Characters toward the block
    output logic [7:0] rx_uart_byte_o = 8'h00,
    output logic rx_uart_valid_o = 1'b0,
    output logic [7:0] rx_ir_byte_o = 8'h00,
    output logic rx_ir_valid_o = 1'b0
);
    logic [7:0] got [$];

    // Takes one waiting character every other cycle unless stalled
    always @(posedge mclk_i) begin
        tx_take_o <= 1'b0;
        if ((tx_uart_valid_i | tx_ir_valid_i) && !stall_i && !tx_take_o) begin
            got.push_back(tx_byte_i);
            tx_take_o <= 1'b1;
        end
    end

    // One-cycle pulse; byte lines invert afterwards so stale data fails
    task send(input logic ir, input logic [7:0] b);
        @(posedge mclk_i);
        if (ir) begin
            rx_ir_byte_o <= b;
            rx_ir_valid_o <= 1'b1;
        end else begin
            rx_uart_byte_o <= b;
            rx_uart_valid_o <= 1'b1;
        end
        @(posedge mclk_i);
        rx_ir_valid_o <= 1'b0;
        rx_uart_valid_o <= 1'b0;
        rx_ir_byte_o <= ~b;
        rx_uart_byte_o <= ~b;
        // One more edge so flags set by the arrival have settled
        @(posedge mclk_i);
    endtask : send
endmodule : usda_peer

// ### dv/usda_asserts.sv
// Concurrent checks on the aliased UART data port
`timescale 1ns/1ps
module usda_asserts (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register bus
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Line side and flags
    input wire logic rx_uart_valid_i,
    input wire logic rx_ir_valid_i,
    input wire logic tx_uart_valid_o,
    input wire logic tx_ir_valid_o,
    input wire logic rx_data_ready_flag_o,
    input wire logic tx_holding_empty_flag_o,
    input wire logic overrun_o,
    input wire logic fifo_enable_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // Helper terms
    logic wtake, artake, rx_in, in_win;
    assign wtake = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
        && s_axi_wready_o;
    assign artake = s_axi_arvalid_i && s_axi_arready_o;
    assign rx_in = rx_uart_valid_i | rx_ir_valid_i;
    assign in_win = (s_axi_awaddr_i >= usda_pkg::ALIAS_BASE) &&
        (s_axi_awaddr_i < usda_pkg::ALIAS_BASE + usda_pkg::ALIAS_SPAN);

    AST_B_LATE: assert property (
        wtake |=> !s_axi_bvalid_o ##1 s_axi_bvalid_o)
        else $error("write response not two cycles after take");
    AST_R_NEXT: assert property (
        artake |=> s_axi_rvalid_o)
        else $error("read data not one cycle after take");
    AST_R_HOLD: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped before ready");
    AST_B_HOLD: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped before ready");
    AST_HI_ZERO: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 0)
        else $error("upper read bits not zero");
    AST_TX_HOLDING_EMPTY_FLAG_CLR: assert property (
        wtake && in_win && s_axi_wstrb_i[0] &&
        !fifo_enable_o && tx_holding_empty_flag_o |=> ##1
        !tx_holding_empty_flag_o)
        else $error("holding empty not cleared by write");
    AST_DR_SET: assert property (
        rx_in |=> rx_data_ready_flag_o)
        else $error("data ready not set by arrival");
    AST_OVR: assert property (
        !fifo_enable_o && rx_data_ready_flag_o && rx_in
        && !artake |=> overrun_o)
        else $error("overrun not flagged on unread buffer");
    AST_TX_LVL: assert property (
        !(tx_uart_valid_o && tx_ir_valid_o) &&
        ((tx_uart_valid_o | tx_ir_valid_o) != tx_holding_empty_flag_o))
        else $error("transmit valid disagrees with holding empty");

    // Main scenarios reached
    COV_FIFO: cover property (fifo_enable_o && !tx_holding_empty_flag_o);
    COV_OVR: cover property ($rose(overrun_o));
    COV_IR: cover property (tx_ir_valid_o);
endmodule : usda_asserts

bind usda_top usda_asserts u_usda_asserts (.*);

// ### dv/testbench.sv
// Self-checking bench for the aliased UART data port
`timescale 1ns/1ps
module testbench;
    localparam logic [31:0] AB = usda_pkg::ALIAS_BASE;
    localparam logic [31:0] A2 = usda_pkg::ALIAS_2_ADDR;
    localparam logic [31:0] CT = usda_pkg::CTRL_ADDR;
    localparam logic [1:0] OK = usda_pkg::RESP_OKAY;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0;
    logic [31:0] s_axi_araddr_i = 32'h0, s_axi_rdata_o;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, stall = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, tx_take_i;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [7:0] rx_uart_byte_i, rx_ir_byte_i, tx_byte_o;
    logic rx_uart_valid_i, rx_ir_valid_i, tx_uart_valid_o, tx_ir_valid_o;
    logic rx_data_ready_flag_o, tx_holding_empty_flag_o;
    logic overrun_o, fifo_enable_o;
    logic [31:0] v;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    usda_top u_usda_top (.*);
    usda_peer u_usda_peer (
        .mclk_i(mclk_i), .stall_i(stall), .tx_byte_i(tx_byte_o),
        .tx_uart_valid_i(tx_uart_valid_o), .tx_ir_valid_i(tx_ir_valid_o),
        .tx_take_o(tx_take_i), .rx_uart_byte_o(rx_uart_byte_i),
        .rx_uart_valid_o(rx_uart_valid_i), .rx_ir_byte_o(rx_ir_byte_i),
        .rx_ir_valid_o(rx_ir_valid_i)
    );

    // Clock and hang guard; whole run is a few hundred cycles
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end

    task give_verdict;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk

    // Write with address and data offered together; waits for response
    task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge mclk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (!got) begin
            @(posedge mclk_i);
            if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o === 1'b1) got = 1'b1;
        end
        s_axi_bready_i <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp_o}, {30'h0, er});
    endtask : wr

    task rd(input logic [31:0] a, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge mclk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        while (!got) begin
            @(posedge mclk_i);
            if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o === 1'b1) got = 1'b1;
        end
        v = s_axi_rdata_o;
        s_axi_rready_i <= 1'b0;
        chk("rresp", {30'h0, s_axi_rresp_o}, {30'h0, er});
    endtask : rd

    task t_reset;
        chk("tx_holding_empty_flag", tx_holding_empty_flag_o, 32'h1);
        chk("dr", rx_data_ready_flag_o, 32'h0);
        rd(A2, OK);
        chk("alias2", v, 32'h0);
        rd(AB + 32'h40, usda_pkg::RESP_SLVERR);
        chk("unmap", v, 32'h0);
        wr(AB + 32'h40, 32'h11, usda_pkg::RESP_SLVERR);
        chk("tx_holding_empty_flag", tx_holding_empty_flag_o, 32'h1);
    endtask : t_reset

    task t_rx_buf;
        u_usda_peer.send(1'b0, 8'h5a);
        chk("dr", rx_data_ready_flag_o, 32'h1);
        rd(AB + 32'h3c, OK);
        chk("rx", v, 32'h5a);
        chk("dr", rx_data_ready_flag_o, 32'h0);
        u_usda_peer.send(1'b0, 8'ha5);
        u_usda_peer.send(1'b0, 8'h3c);
        chk("ovr", overrun_o, 32'h1);
        rd(AB, OK);
        chk("rx", v, 32'h3c);
        rd(usda_pkg::LINE_STATUS_ADDR, OK);
        chk("lsr", v, 32'h22);
        chk("ovr", overrun_o, 32'h0);
    endtask : t_rx_buf

    // Far side stalled so the pending character can be replaced
    task t_tx_buf;
        stall <= 1'b1;
        wr(A2, 32'h1234, OK);
        chk("tx_holding_empty_flag", tx_holding_empty_flag_o, 32'h0);
        chk("txb", tx_byte_o, 32'h34);
        chk("txv", tx_uart_valid_o, 32'h1);
        wr(A2, 32'hff56, OK);
        chk("txb", tx_byte_o, 32'h56);
        s_axi_wstrb_i <= 4'he;
        wr(A2, 32'h77, OK);
        s_axi_wstrb_i <= 4'hf;
        chk("txb", tx_byte_o, 32'h56);
        stall <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("sent", u_usda_peer.got.size(), 32'h1);
        chk("sent0", u_usda_peer.got[0], 32'h56);
        chk("tx_holding_empty_flag", tx_holding_empty_flag_o, 32'h1);
        u_usda_peer.got.delete();
    endtask : t_tx_buf

    // Seventeen characters each way into sixteen-deep stores
    task t_fifo;
        int i;
        wr(CT, 32'h1, OK);
        chk("fen", fifo_enable_o, 32'h1);
        stall <= 1'b1;
        for (i = 0; i < 17; i++) wr(AB + 32'((i % 16) * 4), 32'h10 + i, OK);
        chk("tx_holding_empty_flag", tx_holding_empty_flag_o, 32'h0);
        stall <= 1'b0;
        repeat (40) @(posedge mclk_i);
        chk("sent", u_usda_peer.got.size(), 32'h10);
        for (i = 0; i < 16; i++) begin
            chk("fifo", u_usda_peer.got[i], 32'h10 + i);
        end
        u_usda_peer.got.delete();
        for (i = 0; i < 17; i++) u_usda_peer.send(1'b0, 8'h40 + 8'(i));
        chk("ovr", overrun_o, 32'h1);
        for (i = 0; i < 16; i++) begin
            rd(A2, OK);
            chk("rxq", v, 32'h40 + i);
        end
        chk("dr", rx_data_ready_flag_o, 32'h0);
    endtask : t_fifo

    task t_ir;
        wr(CT, 32'h3, OK);
        rd(CT, OK);
        chk("ctrl", v, 32'h3);
        u_usda_peer.send(1'b1, 8'h99);
        rd(A2, OK);
        chk("irrx", v, 32'h99);
        stall <= 1'b1;
        wr(A2, 32'h66, OK);
        chk("irv", tx_ir_valid_o, 32'h1);
        chk("uv", tx_uart_valid_o, 32'h0);
        stall <= 1'b0;
    endtask : t_ir

    // Main sequence; tests also write while holding empty is clear
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_reset();
        t_rx_buf();
        t_tx_buf();
        t_fifo();
        t_ir();
        give_verdict();
    end
endmodule : testbench
